// ===== common/cnt_mode_pkg.sv
// package: register map, field positions, reset values and timebase codes
package cnt_mode_pkg;

    // register addresses
    localparam logic [7:0] COUNTER_MODE_ADDR = 8'hD9;
    localparam logic [7:0] PWM_CONFIGURATION_ADDR = 8'hF7;
    // our own registers: counter value low/high, irq status, irq mask
    localparam logic [7:0] COUNT_LO_ADDR = 8'hE9;
    localparam logic [7:0] COUNT_HI_ADDR = 8'hF9;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'hE0;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'hE1;

    // counter_mode field positions
    localparam int IDLE_SUSPEND_BIT = 7;
    localparam int WDOG_ENABLE_BIT = 6;
    localparam int WDOG_LOCK_BIT = 5;
    localparam int UNUSED_MODE_BIT = 4;
    localparam int TIMEBASE_LSB = 1;
    localparam int OVF_IRQ_EN_BIT = 0;

    // reset values
    localparam logic [7:0] COUNTER_MODE_RESET = 8'h40;
    localparam logic [7:0] PWM_CONFIG_RESET = 8'h00;
    // unimplemented bit 4 in both registers
    localparam logic [7:0] MODE_WRITE_MASK = 8'hEF;
    localparam logic [7:0] PWM_WRITE_MASK = 8'hEF;

    // timebase select codes
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4 = 3'h1;
    localparam logic [2:0] TB_TIMER0 = 3'h2;
    localparam logic [2:0] TB_EXT_FALL = 3'h3;
    localparam logic [2:0] TB_SYSCLK = 3'h4;
    localparam logic [2:0] TB_EXTOSC_DIV8 = 3'h5;

    // prescaler terminal counts
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [2:0] EXT_DIV8_LAST = 3'h7;

    // interrupt status bit positions
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_WDOG_CHANGE_BIT = 1;
    localparam logic [7:0] IRQ_IMPL_MASK = 8'h03;

    // decoded counter_mode fields
    typedef struct packed {
        logic idle_suspend;
        logic wdog_enable;
        logic wdog_lock;
        logic unused;
        logic [2:0] timebase_select;
        logic overflow_irq_enable;
    } counter_mode_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// ===== verilog/counter_array_mode_control.sv
// counter array mode control: mode register, timebase, idle gating, overflow irq
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps

// How it works
// - idle_suspend halts the counter while CPU idles
// - wdog_enable turns module 2 into watchdog
// - wdog_lock blocks disabling until next reset
// - timebase codes pick div12, div4, timer0, sysclk
// - code 011 counts external input falling edges
// - code 101 counts synchronised external oscillator/8
// - overflow_irq_enable gates overflow flag to interrupt
// - watchdog on freezes other mode bits
// - mode bit 4 reads zero, ignores writes
// - reset leaves watchdog enabled, others cleared
// - writing enable or lock sets watchdog on
// - wrap to zero sets flag; software clears
module counter_array_mode_control (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // system status and count sources
    input wire logic cpu_idle_in,
    input wire logic counter_run_in,
    input wire logic overflow_flag_clear_in,
    input wire logic timer0_overflow_in,
    input wire logic external_count_input_in,
    input wire logic ext_osc_clk_in,
    // results
    output logic [15:0] count_value_out,
    output logic count_tick_out,
    output logic counter_overflow_flag_out,
    output logic counter_irq_out,
    output logic wdog_active_out,
    output logic [7:0] pwm_configuration_out,
    output logic irq_out
);

    // ---------------------------------------------------------------
    // register port decode
    // ---------------------------------------------------------------
    // strobes, address and data travel together as one bundle
    cnt_mode_pkg::reg_req_t req; // bundled bus request
    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    // address compares, one per mapped register
    wire sel_mode = (req.addr == cnt_mode_pkg::COUNTER_MODE_ADDR);
    wire sel_pwm = (req.addr == cnt_mode_pkg::PWM_CONFIGURATION_ADDR);
    wire sel_lo = (req.addr == cnt_mode_pkg::COUNT_LO_ADDR);
    wire sel_hi = (req.addr == cnt_mode_pkg::COUNT_HI_ADDR);
    wire sel_stat = (req.addr == cnt_mode_pkg::IRQ_STATUS_ADDR);
    wire sel_mask = (req.addr == cnt_mode_pkg::IRQ_MASK_ADDR);
    // qualified strobes; unmapped addresses fall through unseen,
    // so a stray write cannot disturb any register
    wire wr_mode = req.wr && sel_mode;
    wire wr_pwm = req.wr && sel_pwm;
    wire wr_mask = req.wr && sel_mask;
    wire rd_stat = req.rd && sel_stat;

    // ---------------------------------------------------------------
    // mode register
    // ---------------------------------------------------------------
    logic [7:0] mode_ff; // counter_mode storage
    logic [7:0] nxt_mode; // its next value
    cnt_mode_pkg::counter_mode_t mode; // field view
    assign mode = cnt_mode_pkg::counter_mode_t'(mode_ff);

    // written value with the unimplemented bit dropped
    // bit 4 ignored
    wire [7:0] wr_clean = req.wdata & cnt_mode_pkg::MODE_WRITE_MASK;
    wire wr_en_bit = wr_clean[cnt_mode_pkg::WDOG_ENABLE_BIT];
    wire wr_lock_bit = wr_clean[cnt_mode_pkg::WDOG_LOCK_BIT];
    // lock holds enable on; lock itself is sticky
    wire keep_on = mode.wdog_lock;
    // either bit written as one turns the watchdog on
    wire new_enable = wr_en_bit | wr_lock_bit | keep_on;
    // lock can only be set; a reset is its only clear
    wire new_lock = wr_lock_bit | mode.wdog_lock;

    // next mode value; frozen fields while watchdog runs
    always_comb begin
        // default: hold every bit
        nxt_mode = mode_ff;
        if (wr_mode) begin
            if (mode.wdog_enable) begin
                // only watchdog bits may move while enabled
                nxt_mode[cnt_mode_pkg::WDOG_ENABLE_BIT] = new_enable;
                nxt_mode[cnt_mode_pkg::WDOG_LOCK_BIT] = new_lock;
            end else begin
                // watchdog off: every writable bit may change
                // free write; enable/lock still obey set semantics
                nxt_mode = wr_clean;
                nxt_mode[cnt_mode_pkg::WDOG_ENABLE_BIT] = new_enable;
                nxt_mode[cnt_mode_pkg::WDOG_LOCK_BIT] = new_lock;
            end
        end
    end

    // mode register flop
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            mode_ff <= cnt_mode_pkg::COUNTER_MODE_RESET;
        end else begin
            // take the filtered next value
            mode_ff <= nxt_mode;
        end
    end

    // pwm configuration: layout only, bit 4 reads zero
    logic [7:0] pwm_ff; // stored configuration
    // register view only; no pwm engine lives in this block
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pwm_ff <= cnt_mode_pkg::PWM_CONFIG_RESET;
        end else if (wr_pwm) begin
            // bit 4 is read-only and forced low
            pwm_ff <= req.wdata & cnt_mode_pkg::PWM_WRITE_MASK;
        end
    end

    // ---------------------------------------------------------------
    // external input and oscillator synchronisers
    // ---------------------------------------------------------------
    // count pin stages; the pin idles high
    logic eci_s1_ff; // first stage, read only by second
    logic eci_s2_ff; // synchronised level
    logic eci_s3_ff; // previous synchronised level
    // external oscillator stages; the oscillator idles low
    logic osc_s1_ff; // first stage, read only by second
    logic osc_s2_ff;
    logic osc_s3_ff;
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            // each stage resets to its pin's idle level: no false edge
            eci_s1_ff <= 1'b1;
            eci_s2_ff <= 1'b1;
            eci_s3_ff <= 1'b1;
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_s3_ff <= 1'b0;
        end else begin
            // first stages feed only the second stages
            eci_s1_ff <= external_count_input_in;
            eci_s2_ff <= eci_s1_ff;
            eci_s3_ff <= eci_s2_ff;
            osc_s1_ff <= ext_osc_clk_in;
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
        end
    end
    // limitation: a pin pulse under one clock wide may be lost
    // falling edge from synchronised samples only
    wire eci_fall = eci_s3_ff & ~eci_s2_ff;
    // rising edge of the oscillator; osc must be under half sysclk
    wire osc_rise = osc_s2_ff & ~osc_s3_ff;

    // ---------------------------------------------------------------
    // prescalers
    // ---------------------------------------------------------------
    logic [3:0] pre_ff; // sysclk prescaler
    logic [2:0] osc_div_ff; // oscillator edge divider
    // one shared prescaler serves both divided system clock modes;
    // the >= compare stops a switch from div12 to div4 with a high
    // count running the 4-bit value round before the next tick
    wire pre_last = (mode.timebase_select == cnt_mode_pkg::TB_DIV4)
        ? (pre_ff >= cnt_mode_pkg::DIV4_LAST) : (pre_ff >= cnt_mode_pkg::DIV12_LAST);
    wire osc_last = osc_rise && (osc_div_ff == cnt_mode_pkg::EXT_DIV8_LAST);
    wire halted = mode.idle_suspend && cpu_idle_in;
    // counter_run_in is the run control held outside this block
    wire running = counter_run_in && !halted;

    // prescaler counting; shared wrap compare by mode
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            // every divider starts from zero
            pre_ff <= 4'h0;
            osc_div_ff <= 3'h0;
        end else if (running) begin
            // a halted counter also freezes its dividers
            pre_ff <= pre_last ? 4'h0 : pre_ff + 4'h1;
            // divide synchronised oscillator edges by eight
            if (osc_rise) begin
                osc_div_ff <= osc_div_ff + 3'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // timebase selection
    // ---------------------------------------------------------------
    // only the selected source reaches the counter
    logic tick; // one-cycle count enable
    always_comb begin
        // select field decoded straight from the mode flop
        unique case (mode.timebase_select)
            cnt_mode_pkg::TB_DIV12: tick = pre_last;
            cnt_mode_pkg::TB_DIV4: tick = pre_last;
            cnt_mode_pkg::TB_TIMER0: tick = timer0_overflow_in;
            cnt_mode_pkg::TB_EXT_FALL: tick = eci_fall;
            cnt_mode_pkg::TB_SYSCLK: tick = 1'b1;
            cnt_mode_pkg::TB_EXTOSC_DIV8: tick = osc_last;
            default: tick = 1'b0;
        endcase
    end
    // the tick only counts while the array runs
    wire count_en = running && tick;

    // ---------------------------------------------------------------
    // counter and overflow flag
    // ---------------------------------------------------------------
    // the counter itself and its wrap detect
    logic [15:0] count_ff;
    logic ovf_ff;
    logic tick_ff;
    // wrap: an enabled tick at the top value
    wire wrap = count_en && (count_ff == 16'hFFFF);
    // counter, tick and overflow flag flops
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            count_ff <= 16'h0000;
            ovf_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            // tick output is registered with the increment: it rises in the same clock as the new count
            tick_ff <= count_en;
            // increment only on an enabled tick
            if (count_en) begin
                count_ff <= count_ff + 16'h0001;
            end
            // set on wrap beats software clear
            ovf_ff <= wrap | (ovf_ff & ~overflow_flag_clear_in);
        end
    end

    // ---------------------------------------------------------------
    // interrupt status and mask
    // ---------------------------------------------------------------
    logic [7:0] stat_ff;
    logic [7:0] mask_ff;
    // bit 0 counter wrap, bit 1 mode register changed by a write
    wire [7:0] events = {6'h00, (wr_mode && (nxt_mode != mode_ff)), wrap};
    // sticky events; read clears, new event wins
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            stat_ff <= 8'h00;
            mask_ff <= 8'h00;
        end else begin
            // read clears first, then new events are or'd back in
            stat_ff <= events | (rd_stat ? 8'h00 : stat_ff);
            if (wr_mask) begin
                // mask keeps only the implemented bits
                mask_ff <= req.wdata & cnt_mode_pkg::IRQ_IMPL_MASK;
            end
        end
    end

    // ---------------------------------------------------------------
    // read data, one cycle after the strobe
    // ---------------------------------------------------------------
    // the same address compares steer the read mux
    wire [7:0] rd_mux = sel_mode ? mode_ff :
                        sel_pwm ? pwm_ff :
                        sel_lo ? count_ff[7:0] :
                        sel_hi ? count_ff[15:8] :
                        sel_stat ? stat_ff :
                        sel_mask ? mask_ff : 8'h00;
    logic [7:0] rdata_ff;
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rdata_ff <= 8'h00;
        end else begin
            // zero outside the answer cycle, so a stray sample is harmless
            rdata_ff <= req.rd ? rd_mux : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign reg_rdata_out = rdata_ff;
    assign count_value_out = count_ff;
    assign count_tick_out = tick_ff;
    assign counter_overflow_flag_out = ovf_ff;
    assign counter_irq_out = ovf_ff && mode.overflow_irq_enable;
    // module 2 acts as watchdog while enabled
    assign wdog_active_out = mode.wdog_enable;
    // configuration bits handed on to the pwm logic
    assign pwm_configuration_out = pwm_ff;
    // level request while any unmasked status bit stands
    assign irq_out = |(stat_ff & mask_ff);

endmodule

// ===== sim/cnt_mode_chk.sv
// checker: port-level assertions for the counter array mode control
`timescale 1ns/10ps
module cnt_mode_chk (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // counting and status
    input wire logic counter_run_in,
    input wire logic overflow_flag_clear_in,
    input wire logic [15:0] count_value_out,
    input wire logic count_tick_out,
    input wire logic counter_overflow_flag_out,
    input wire logic counter_irq_out,
    input wire logic wdog_active_out
);
    // ------------------------------------------
    // one clock domain, one default for all
    // ------------------------------------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);
    // answer cycle of a mode register read
    sequence s_mode_rd;
        $past(reg_rd_in) && $past(reg_addr_in) == cnt_mode_pkg::COUNTER_MODE_ADDR;
    endsequence
    // counter wrapping past its top
    sequence s_wrap;
        $past(count_value_out) == 16'hFFFF && count_value_out == 16'h0000;
    endsequence
    // any move of the counter
    sequence s_step;
        count_value_out != $past(count_value_out);
    endsequence
    a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside answer cycle");
    a_mode_view: assert property (s_mode_rd |-> reg_rdata_out[4] == 1'b0 &&
        reg_rdata_out[6] == $past(wdog_active_out)) else $error("mode read mismatch");
    a_wrap_flag: assert property (s_wrap |-> ##[0:1] counter_overflow_flag_out)
        else $error("wrap did not set flag");
    a_count_step: assert property (s_step |->
        count_value_out == $past(count_value_out) + 16'h1) else $error("counter jumped");
    a_tick_follow: assert property (s_step |-> count_tick_out)
        else $error("no tick after increment");
    a_stop_hold: assert property (!counter_run_in |=> $stable(count_value_out))
        else $error("counter moved while stopped");
    a_irq_gate: assert property (counter_irq_out |-> counter_overflow_flag_out)
        else $error("irq without flag");
    a_flag_clear: assert property (overflow_flag_clear_in && count_value_out != 16'hFFFF &&
        count_value_out != 16'h0000 |=> !counter_overflow_flag_out) else $error("flag kept");
    a_wdog_set: assert property (reg_wr_in &&
        reg_addr_in == cnt_mode_pkg::COUNTER_MODE_ADDR && (reg_wdata_in[6] || reg_wdata_in[5])
        |=> wdog_active_out) else $error("wdog not on");
    a_wdog_fall: assert property ($fell(wdog_active_out) |-> $past(reg_wr_in) &&
        !$past(reg_wdata_in[6])) else $error("wdog dropped without write");
endmodule

bind counter_array_mode_control cnt_mode_chk u_cnt_mode_chk (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .counter_run_in(counter_run_in),
    .overflow_flag_clear_in(overflow_flag_clear_in),
    .count_value_out(count_value_out),
    .count_tick_out(count_tick_out),
    .counter_overflow_flag_out(counter_overflow_flag_out),
    .counter_irq_out(counter_irq_out),
    .wdog_active_out(wdog_active_out)
);

// ===== sim/tb.sv
// bench: self-checking test of the counter array mode control
`timescale 1ns/10ps
module tb;
    // ------------------------------------------
    // stimulus, observation, bookkeeping
    // ------------------------------------------
    localparam logic [7:0] MD = cnt_mode_pkg::COUNTER_MODE_ADDR;
    localparam logic [7:0] PW = cnt_mode_pkg::PWM_CONFIGURATION_ADDR;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    cnt_mode_pkg::reg_req_t req = '0; // bus carrier
    logic run = 1'b0, idle = 1'b0, clr = 1'b0, t0 = 1'b0, pin = 1'b1, osc = 1'b0;
    logic [7:0] rdata, pwm;
    logic [15:0] cnt;
    logic tick_o, flag, cirq, wdog, irq, rd_seen = 1'b0;
    logic [7:0] exp_q[$]; // read expectations, oldest first
    int err_total = 0, n_compared = 0;
    logic [15:0] exp_cnt = 16'h0000; // running count
    logic [31:0] rnd = 32'h0000695A;
    logic [2:0] codes[3] = '{cnt_mode_pkg::TB_SYSCLK, cnt_mode_pkg::TB_DIV4,
        cnt_mode_pkg::TB_DIV12};
    int divs[3] = '{1, 4, 12};

    always #5 sys_clk_in = ~sys_clk_in;

    counter_array_mode_control u_counter_array_mode_control (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_addr_in(req.addr),
        .reg_wdata_in(req.wdata), .reg_wr_in(req.wr), .reg_rd_in(req.rd),
        .reg_rdata_out(rdata), .cpu_idle_in(idle), .counter_run_in(run),
        .overflow_flag_clear_in(clr), .timer0_overflow_in(t0),
        .external_count_input_in(pin), .ext_osc_clk_in(osc), .count_value_out(cnt),
        .count_tick_out(tick_o), .counter_overflow_flag_out(flag), .counter_irq_out(cirq),
        .wdog_active_out(wdog), .pwm_configuration_out(pwm), .irq_out(irq));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk_read(input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("wrong value read data expected %h seen %h", e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_in);
        req <= '{a, v, 1'b1, 1'b0};
        @(posedge sys_clk_in);
        req.wr <= 1'b0;
    endtask
    // the answer is judged by the monitor below
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_in);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        exp_q.push_back(e);
        @(posedge sys_clk_in);
        req.rd <= 1'b0;
    endtask
    task automatic reset_pulse();
        @(posedge sys_clk_in);
        reset_in <= 1'b1;
        tick(5);
        reset_in <= 1'b0;
    endtask
    task automatic run_for(input int n);
        @(posedge sys_clk_in);
        run <= 1'b1;
        tick(n);
        run <= 1'b0;
    endtask
    // pin and oscillator always toggle, timer0 only under its own code; the code decides which one counts
    task automatic burst(input logic [2:0] c);
        wr(MD, {4'h0, c, 1'b0});
        @(posedge sys_clk_in);
        run <= 1'b1;
        repeat (16) begin
            t0 <= (c == cnt_mode_pkg::TB_TIMER0);
            pin <= 1'b0;
            osc <= 1'b1;
            tick(2);
            t0 <= 1'b0;
            pin <= 1'b1;
            osc <= 1'b0;
            tick(2);
        end
        tick(4); // let synchroniser latency drain
        run <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // monitor: read data stands only in the cycle after the strobe
    always @(posedge sys_clk_in) rd_seen <= req.rd;
    always @(negedge sys_clk_in) begin
        if (rd_seen)
            chk_read(exp_q.pop_front(), rdata);
    end

    // watchdog: tests take about 66k cycles
    initial begin
        tick(80000);
        err_total++;
        wrap_up();
    end

    initial begin
        // reset held for five clocks at the start
        tick(5);
        reset_in <= 1'b0;
        rd(MD, 8'h40);
        rd(8'hE5, 8'h00);
        wr(MD, 8'hDB);
        rd(MD, 8'h40);
        wr(MD, 8'h00);
        rd(MD, 8'h00);
        @(negedge sys_clk_in);
        chk("wdog", 16'h0000, wdog);
        wr(MD, 8'h10);
        rd(MD, 8'h00);
        repeat (4) begin
            rnd = xs(rnd);
            wr(PW, rnd[7:0]);
            rd(PW, rnd[7:0] & 8'hEF);
            @(negedge sys_clk_in);
            chk("pwm out", {8'h00, rnd[7:0] & 8'hEF}, {8'h00, pwm});
        end
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            wr(MD, {4'h0, codes[i], 1'b0});
            run_for(24);
            exp_cnt += 16'(24 / divs[i]);
        end
        burst(cnt_mode_pkg::TB_TIMER0);
        burst(cnt_mode_pkg::TB_EXT_FALL);
        burst(cnt_mode_pkg::TB_EXTOSC_DIV8);
        idle <= 1'b1;
        wr(MD, 8'h88);
        run_for(24);
        wr(MD, 8'h08);
        run_for(12);
        idle <= 1'b0;
        exp_cnt += 16'h003E;
        rd(cnt_mode_pkg::COUNT_LO_ADDR, exp_cnt[7:0]);
        rd(cnt_mode_pkg::COUNT_HI_ADDR, exp_cnt[15:8]);
        $display("test timebase done");
        wr(MD, 8'h09);
        rd(cnt_mode_pkg::IRQ_STATUS_ADDR, 8'h02);
        wr(cnt_mode_pkg::IRQ_MASK_ADDR, 8'h01);
        run_for(65536 - 94);
        tick(3);
        @(negedge sys_clk_in);
        chk("flag", 16'h0001, flag);
        chk("counter irq", 16'h0001, cirq);
        chk("irq", 16'h0001, irq);
        wr(cnt_mode_pkg::IRQ_MASK_ADDR, 8'h00);
        @(negedge sys_clk_in);
        chk("masked irq", 16'h0000, irq);
        rd(cnt_mode_pkg::IRQ_STATUS_ADDR, 8'h01);
        rd(cnt_mode_pkg::IRQ_STATUS_ADDR, 8'h00);
        wr(MD, 8'h08);
        @(negedge sys_clk_in);
        chk("counter irq", 16'h0000, cirq);
        chk("flag", 16'h0001, flag);
        run_for(3);
        clr <= 1'b1;
        @(posedge sys_clk_in);
        clr <= 1'b0;
        @(negedge sys_clk_in);
        chk("flag", 16'h0000, flag);
        $display("test overflow done");
        wr(MD, 8'h20);
        rd(MD, 8'h60);
        wr(MD, 8'h00);
        rd(MD, 8'h60);
        reset_pulse();
        rd(MD, 8'h40);
        wr(MD, 8'h00);
        rd(MD, 8'h00);
        tick(3);
        $display("test lock done");
        wrap_up();
    end
endmodule
